// [logic/gpport_top.sv]
// Eight-pin general-purpose port: drive registers, pin configuration, sensing, event flags.
`timescale 1ns/1ps
`default_nettype none
module gpport_top #(
    parameter int PINS = gpport_pkg::PINS,
    parameter logic [PINS-1:0] ASYNC_PINS = '0
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic alias_sel,
    input wire logic [4:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    input wire logic [PINS-1:0] pad_in,
    output logic [PINS-1:0] pad_out,
    output logic [PINS-1:0] pad_oe,
    output logic [PINS-1:0] pad_pullup,
    output logic [PINS-1:0] pad_level,
    output logic irq,
    output logic wake
);
    logic [PINS-1:0] enable_reg;
    logic [PINS-1:0] enable_next;
    logic [PINS-1:0] level_reg;
    logic [PINS-1:0] level_next;
    logic [PINS-1:0] flags_reg;
    logic [PINS-1:0] flags_next;
    logic [7:0] config_reg [PINS];
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic [PINS-1:0] pad_out_reg;
    logic [PINS-1:0] pad_oe_reg;
    logic [PINS-1:0] pad_pullup_reg;
    logic [PINS-1:0] pad_level_reg;
    logic irq_reg;
    logic wake_reg;
    logic [PINS-1:0] sensed;
    logic [PINS-1:0] hits;
    logic [PINS-1:0] wakes;
    logic [PINS-1:0] swaps;
    logic [PINS-1:0] pulls;
    logic [PINS-1:0] armed;
    logic [PINS-1:0] wd;
    logic [4:0] reg_addr;
    logic wr_enable;
    logic wr_en_set;
    logic wr_en_clr;
    logic wr_en_tgl;
    logic wr_level;
    logic wr_lv_set;
    logic wr_lv_clr;
    logic wr_lv_tgl;
    logic wr_flags;
    logic wr_config;
    logic [2:0] cfg_idx;

    // Maps an alias window index onto the regular register offset.
    function automatic logic [4:0] alias_map(input logic [1:0] idx);
        unique case (idx)
            gpport_pkg::ALIAS_ENABLE: alias_map = gpport_pkg::OFS_ENABLE;
            gpport_pkg::ALIAS_LEVEL: alias_map = gpport_pkg::OFS_LEVEL;
            gpport_pkg::ALIAS_SAMPLED: alias_map = gpport_pkg::OFS_SAMPLED;
            gpport_pkg::ALIAS_FLAGS: alias_map = gpport_pkg::OFS_FLAGS;
        endcase
    endfunction

    // Alias accesses fold into the same decode as regular accesses.
    assign reg_addr = alias_sel ? alias_map(addr[1:0]) : addr;
    assign wd = wdata[PINS-1:0];
    assign wr_enable = wr_en && reg_addr == gpport_pkg::OFS_ENABLE;
    assign wr_en_set = wr_en && reg_addr == gpport_pkg::OFS_ENABLE_SET;
    assign wr_en_clr = wr_en && reg_addr == gpport_pkg::OFS_ENABLE_CLR;
    assign wr_en_tgl = wr_en && reg_addr == gpport_pkg::OFS_ENABLE_TGL;
    assign wr_level = wr_en && reg_addr == gpport_pkg::OFS_LEVEL;
    assign wr_lv_set = wr_en && reg_addr == gpport_pkg::OFS_LEVEL_SET;
    assign wr_lv_clr = wr_en && reg_addr == gpport_pkg::OFS_LEVEL_CLR;
    // Writing ones to the sampled-level register toggles the drive level.
    assign wr_lv_tgl = wr_en && (reg_addr == gpport_pkg::OFS_LEVEL_TGL
        || reg_addr == gpport_pkg::OFS_SAMPLED);
    assign wr_flags = wr_en && reg_addr == gpport_pkg::OFS_FLAGS;
    assign wr_config = wr_en && reg_addr[4] && reg_addr[3] == 1'b0;
    assign cfg_idx = reg_addr[2:0];

    // Next drive enable from full write, set, clear and toggle ports.
    assign enable_next = wr_enable ? wd :
        wr_en_set ? (enable_reg | wd) :
        wr_en_clr ? (enable_reg & ~wd) :
        wr_en_tgl ? (enable_reg ^ wd) : enable_reg;

    // Next drive level from full write, set, clear and toggle ports.
    assign level_next = wr_level ? wd :
        wr_lv_set ? (level_reg | wd) :
        wr_lv_clr ? (level_reg & ~wd) :
        wr_lv_tgl ? (level_reg ^ wd) : level_reg;

    // Hardware set beats the software write-one clear.
    assign flags_next = (flags_reg & ~(wr_flags ? wd : '0)) | hits;

    // Per-pin sensors and configuration fan-out.
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi++) begin : g_pin
            gpport_pin_if pin_bus ();
            assign pin_bus.swap = config_reg[gi][gpport_pkg::CFG_SWAP_BIT];
            assign pin_bus.sense = config_reg[gi][2:0];
            assign pin_bus.pad_in = pad_in[gi];
            assign pin_bus.async_pin = ASYNC_PINS[gi];
            assign sensed[gi] = pin_bus.level;
            assign hits[gi] = pin_bus.event_hit;
            assign wakes[gi] = pin_bus.wake;
            assign swaps[gi] = pin_bus.swap;
            assign pulls[gi] = config_reg[gi][gpport_pkg::CFG_PULL_BIT];
            // Interrupt enabled unless sense is off or interrupt-disabled.
            assign armed[gi] = pin_bus.sense != gpport_pkg::SENSE_INTDIS
                && pin_bus.sense != gpport_pkg::SENSE_OFF;
            gpport_sensor u_sensor (
                .ref_clk(ref_clk),
                .nrst(nrst),
                .pin(pin_bus.sensor)
            );
        end
    endgenerate

    // Read data: set/clear/toggle ports read back their base register.
    always_comb begin
        rdata_next = gpport_pkg::RESET_BYTE;
        if (rd_en) begin
            if (reg_addr[4] && reg_addr[3] == 1'b0) begin
                rdata_next = config_reg[cfg_idx];
            end else begin
                unique case (reg_addr)
                    gpport_pkg::OFS_ENABLE, gpport_pkg::OFS_ENABLE_SET,
                    gpport_pkg::OFS_ENABLE_CLR, gpport_pkg::OFS_ENABLE_TGL:
                        rdata_next = 8'(enable_reg);
                    gpport_pkg::OFS_LEVEL, gpport_pkg::OFS_LEVEL_SET,
                    gpport_pkg::OFS_LEVEL_CLR, gpport_pkg::OFS_LEVEL_TGL:
                        rdata_next = 8'(level_reg);
                    gpport_pkg::OFS_SAMPLED: rdata_next = 8'(sensed);
                    gpport_pkg::OFS_FLAGS: rdata_next = 8'(flags_reg);
                    default: rdata_next = gpport_pkg::RESET_BYTE;
                endcase
            end
        end
    end

    // Drive registers; reset leaves every driver off.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            enable_reg <= '0;
            level_reg <= '0;
            flags_reg <= '0;
        end else begin
            enable_reg <= enable_next;
            level_reg <= level_next;
            flags_reg <= flags_next;
        end
    end

    // Per-pin configuration, independent of sleep.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < PINS; i++) begin
                config_reg[i] <= gpport_pkg::RESET_BYTE;
            end
        end else if (wr_config && int'(cfg_idx) < PINS) begin
            config_reg[cfg_idx] <= wdata & gpport_pkg::CFG_WRITE_MASK;
        end
    end

    // Registered outputs toward the pads and the system.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_reg <= gpport_pkg::RESET_BYTE;
            pad_out_reg <= '0;
            pad_oe_reg <= '0;
            pad_pullup_reg <= '0;
            pad_level_reg <= '0;
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
        end else begin
            rdata_reg <= rdata_next;
            pad_out_reg <= level_next ^ swaps;
            pad_oe_reg <= enable_next;
            pad_pullup_reg <= pulls;
            pad_level_reg <= sensed;
            irq_reg <= |(flags_next & armed);
            wake_reg <= |wakes;
        end
    end

    assign rdata = rdata_reg;
    assign pad_out = pad_out_reg;
    assign pad_oe = pad_oe_reg;
    assign pad_pullup = pad_pullup_reg;
    assign pad_level = pad_level_reg;
    assign irq = irq_reg;
    assign wake = wake_reg;

    oe_follow_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 pad_oe == enable_reg) else $error("driver enable mismatch");
    set_only_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_en_set |=> enable_reg == ($past(enable_reg) | $past(wd))) else $error("set port wrong");
    clr_only_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_en_clr |=> enable_reg == ($past(enable_reg) & ~$past(wd))) else $error("clear wrong");
    tgl_dir_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_en_tgl |=> enable_reg == ($past(enable_reg) ^ $past(wd))) else $error("toggle wrong");
    lv_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_lv_set |=> level_reg == ($past(level_reg) | $past(wd))) else $error("level set wrong");
    lv_clr_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_lv_clr |=> level_reg == ($past(level_reg) & ~$past(wd))) else $error("level clr wrong");
    lv_tgl_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_lv_tgl |=> level_reg == ($past(level_reg) ^ $past(wd))) else $error("level tgl wrong");
    swap_out_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 pad_out == (level_reg ^ $past(swaps))) else $error("polarity not applied");
    flag_set_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        |hits |=> (flags_reg & $past(hits)) == $past(hits)) else $error("event flag lost");
    flag_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_flags && (wd & ~hits) != '0 |=> (flags_reg & $past(wd & ~hits)) == '0)
        else $error("flag not cleared");
    irq_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 irq == |(flags_reg & $past(armed))) else $error("interrupt level wrong");
    cfg_write_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wr_config && cfg_idx == 3'h0 |=> config_reg[0] == ($past(wdata) & 8'h8F))
        else $error("config write lost");
    pull_out_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        ##1 pad_pullup == $past(pulls)) else $error("pull-up not applied");

    cover_set_c: cover property (@(posedge ref_clk) disable iff (!nrst) wr_en_set ##1 pad_oe[0]);
    cover_irq_c: cover property (@(posedge ref_clk) disable iff (!nrst) $rose(irq));
    cover_clear_c: cover property (@(posedge ref_clk) disable iff (!nrst) irq && wr_flags ##1 !irq);
    cover_alias_c: cover property (@(posedge ref_clk) disable iff (!nrst) alias_sel && wr_en);
endmodule
`default_nettype wire

// [logic/gpport_pkg.sv]
// Package with offsets, field layouts, reset values and sense encodings of the pin port.
// Function
// - After reset every pad is an input: driver off, input buffer on.
// - Pin n configuration register sits at byte offset 0x10 plus n.
// - Drive enable bit one turns on pin driver, driving the drive level bit.
// - Drive enable set port sets only the written ones, other pins unchanged.
// - Drive level set writes ones into drive level bits, zeros ignored.
// - Drive level clear clears drive level bits written as one.
// - Drive level toggle or writing sampled levels inverts drive level bits.
// - Writing zero to enable bit or one to clear disables that driver only.
// - Sampled levels return synchronized pin level unless sensing is off.
// - Drive enable toggle inverts the matching enable bit, reversing direction.
// - Alias window reaches enable, level, sampled and flag registers identically.
// - Polarity swap inverts both driven and sensed value of the pin.
// - Toggling polarity swap makes an edge seen by event and interrupt logic.
// - Pull resistor on enables the pull-up on that pin.
// - Sense select enables per-pin interrupt and picks any, rise, fall or low.
// - Non-async pins wake with clock stopped only on any edge or level.
// - Sense condition sets pin flag; interrupt stays high while any flag of a pin with interrupt enabled is set.
// - Synchronous pins need pulses lasting at least one clock cycle.
// - Synchronous pins accept no new event for three cycles after the last.
// - Port runs on main clock; configuration unaffected by sleep.
// - Events may be lost around polarity or sense changes during sync.
// - Sense off stops the pin's input synchronizer to save power.
package gpport_pkg;
    localparam int PINS = 8;
    localparam logic [4:0] OFS_ENABLE = 5'h00;
    localparam logic [4:0] OFS_ENABLE_SET = 5'h01;
    localparam logic [4:0] OFS_ENABLE_CLR = 5'h02;
    localparam logic [4:0] OFS_ENABLE_TGL = 5'h03;
    localparam logic [4:0] OFS_LEVEL = 5'h04;
    localparam logic [4:0] OFS_LEVEL_SET = 5'h05;
    localparam logic [4:0] OFS_LEVEL_CLR = 5'h06;
    localparam logic [4:0] OFS_LEVEL_TGL = 5'h07;
    localparam logic [4:0] OFS_SAMPLED = 5'h08;
    localparam logic [4:0] OFS_FLAGS = 5'h09;
    localparam logic [4:0] OFS_CONFIG = 5'h10;
    localparam logic [1:0] ALIAS_ENABLE = 2'h0;
    localparam logic [1:0] ALIAS_LEVEL = 2'h1;
    localparam logic [1:0] ALIAS_SAMPLED = 2'h2;
    localparam logic [1:0] ALIAS_FLAGS = 2'h3;
    localparam int CFG_SWAP_BIT = 7;
    localparam int CFG_PULL_BIT = 3;
    localparam logic [7:0] CFG_WRITE_MASK = 8'h8F;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int DEAD_CYCLES = 3;
    typedef enum logic [2:0] {
        SENSE_INTDIS = 3'h0,
        SENSE_ANY = 3'h1,
        SENSE_RISE = 3'h2,
        SENSE_FALL = 3'h3,
        SENSE_OFF = 3'h4,
        SENSE_LOW = 3'h5
    } gpport_sense_t;
endpackage

// [logic/gpport_pin_if.sv]
// Interface carrying one pin's configuration and sensing signals between port and sensor.
`timescale 1ns/1ps
`default_nettype none
interface gpport_pin_if;
    logic swap;
    logic [2:0] sense;
    logic pad_in;
    logic async_pin;
    logic level;
    logic event_hit;
    logic wake;
    modport port (output swap, output sense, output pad_in, output async_pin,
        input level, input event_hit, input wake);
    modport sensor (input swap, input sense, input pad_in, input async_pin,
        output level, output event_hit, output wake);
endinterface
`default_nettype wire

// [logic/gpport_sensor.sv]
// Per-pin input synchronizer, sense condition detector and dead-time counter.
`timescale 1ns/1ps
`default_nettype none
module gpport_sensor (
    input wire logic ref_clk,
    input wire logic nrst,
    gpport_pin_if.sensor pin
);
    logic sync1_reg;
    logic sync2_reg;
    logic prev_reg;
    logic [1:0] dead_reg;
    logic [1:0] dead_next;
    logic sense_on;
    logic inv_level;
    logic cond;
    logic hit;

    // Synchronizer runs only while sensing is on.
    assign sense_on = (pin.sense != gpport_pkg::SENSE_OFF);
    // Swap acts after sync so a swap toggle shows as an edge.
    assign inv_level = sync2_reg ^ pin.swap;
    assign pin.level = sense_on ? inv_level : 1'b0;

    // Trigger condition by sense selection.
    always_comb begin
        unique case (pin.sense)
            gpport_pkg::SENSE_ANY: cond = inv_level ^ prev_reg;
            gpport_pkg::SENSE_RISE: cond = inv_level & ~prev_reg;
            gpport_pkg::SENSE_FALL: cond = ~inv_level & prev_reg;
            gpport_pkg::SENSE_LOW: cond = ~inv_level;
            default: cond = 1'b0;
        endcase
    end
    assign hit = cond && (pin.async_pin || dead_reg == 2'h0);
    assign pin.event_hit = hit;
    // Wake request: async pins any setting, others only any edge or low.
    assign pin.wake = cond && (pin.async_pin || pin.sense == gpport_pkg::SENSE_ANY
        || pin.sense == gpport_pkg::SENSE_LOW);
    assign dead_next = hit ? 2'(gpport_pkg::DEAD_CYCLES) :
        (dead_reg != 2'h0 ? dead_reg - 2'h1 : 2'h0);

    // Two-stage synchronizer, held while sensing is off.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else if (sense_on) begin
            sync1_reg <= pin.pad_in;
            sync2_reg <= sync1_reg;
        end
    end

    // Previous level and dead-time count.
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            prev_reg <= 1'b0;
            dead_reg <= 2'h0;
        end else begin
            prev_reg <= inv_level;
            dead_reg <= dead_next;
        end
    end

    dead_load_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        hit && !pin.async_pin |=> dead_reg == 2'h3) else $error("dead time not loaded");
    dead_block_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        hit && !pin.async_pin |=> !hit ##1 !hit ##1 !hit) else $error("event in dead time");
    sync_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        !sense_on |=> $stable(sync2_reg)) else $error("sync ran while off");
    wake_rise_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        pin.wake && !pin.async_pin |-> pin.sense != gpport_pkg::SENSE_RISE)
        else $error("rise wake on sync pin");
endmodule
`default_nettype wire

// [verif/gpport_pads.sv]
// Board-side model of the eight pads: external drivers, pull-ups and floating lines.
`timescale 1ns/1ps
`default_nettype none
module gpport_pads (
    input wire logic ref_clk,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup,
    input wire logic [7:0] ext_val,
    input wire logic [7:0] ext_en,
    output logic [7:0] pad_in
);
    logic [7:0] float_reg = 8'h00;

    // A released line without pull-up shows a pattern that flips every cycle.
    always @(posedge ref_clk) begin
        float_reg <= ~float_reg;
    end

    // Each pad resolves to the port driver, then the board source, then the pull-up.
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            if (pad_oe[n]) begin
                pad_in[n] = pad_out[n];
            end else if (ext_en[n]) begin
                pad_in[n] = ext_val[n];
            end else if (pad_pullup[n]) begin
                pad_in[n] = 1'b1;
            end else begin
                pad_in[n] = float_reg[n];
            end
        end
    end
endmodule
`default_nettype wire

// [verif/gpport_top_tb.sv]
// Self-checking testbench of the eight-pin port.
`timescale 1ns/1ps
`default_nettype none
module gpport_top_tb;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic alias_sel = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] rdata, pad_in, pad_out, pad_oe, pad_pullup, pad_level;
    logic irq, wake;
    logic [7:0] got;
    int miscompares = 0;
    int n_tests = 0;
    int cycles = 0;

    // Clock of 20 ns period.
    always #10 ref_clk = ~ref_clk;

    gpport_top #(.PINS(8)) DUT (.ref_clk(ref_clk), .nrst(nrst), .wr_en(wr_en), .rd_en(rd_en),
        .alias_sel(alias_sel), .addr(addr), .wdata(wdata), .rdata(rdata), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .pad_level(pad_level),
        .irq(irq), .wake(wake));
    gpport_pads pads (.ref_clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .ext_val(ext_val), .ext_en(ext_en), .pad_in(pad_in));

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // A hang is cut short well beyond the expected run length.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic al, input logic [4:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        alias_sel = al;
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        @(negedge ref_clk);
        wr_en = 1'b0;
    endtask

    task automatic rd(input logic al, input logic [4:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        alias_sel = al;
        addr = a;
        rd_en = 1'b1;
        @(negedge ref_clk);
        rd_en = 1'b0;
        d = rdata;
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Port comes out of reset with every driver off and reads as zero.
    task automatic t_reset();
        check(pad_oe, 8'h00);
        check(pad_out, 8'h00);
        rd(1'b0, gpport_pkg::OFS_ENABLE, got);
        check(got, 8'h00);
        rd(1'b0, 5'h0A, got);
        check(got, 8'h00);
    endtask

    // One drive-register write, then pins and both registers are compared.
    task automatic step(input logic [4:0] a, input logic [7:0] d, input logic [7:0] e,
        input logic [7:0] l);
        wr(1'b0, a, d);
        check(pad_oe, e);
        check(pad_out, l);
        rd(1'b0, gpport_pkg::OFS_ENABLE, got);
        check(got, e);
        rd(1'b0, gpport_pkg::OFS_LEVEL, got);
        check(got, l);
    endtask

    // Alias window writes and reads reach the same registers.
    task automatic t_alias();
        wr(1'b1, gpport_pkg::ALIAS_ENABLE, 8'h5A);
        rd(1'b0, gpport_pkg::OFS_ENABLE, got);
        check(got, 8'h5A);
        wr(1'b1, gpport_pkg::ALIAS_LEVEL, 8'hC3);
        rd(1'b0, gpport_pkg::OFS_LEVEL, got);
        check(got, 8'hC3);
        ext_en = 8'hFF;
        ext_val = 8'h0F;
        wait_cyc(4);
        rd(1'b1, gpport_pkg::ALIAS_SAMPLED, got);
        check(got, 8'h47);
        check(pad_level, 8'h47);
        rd(1'b0, gpport_pkg::OFS_SAMPLED, got);
        check(got, 8'h47);
        wr(1'b0, gpport_pkg::OFS_ENABLE, 8'h00);
        wr(1'b0, gpport_pkg::OFS_LEVEL, 8'h00);
    endtask

    // Per-pin configuration: offsets, pull-ups, sense off and polarity swap.
    task automatic t_config();
        ext_en = 8'h00;
        for (int n = 0; n < 8; n++) begin
            wr(1'b0, gpport_pkg::OFS_CONFIG + 5'(n), 8'h08);
            rd(1'b0, gpport_pkg::OFS_CONFIG + 5'(n), got);
            check(got, 8'h08);
        end
        check(pad_pullup, 8'hFF);
        wait_cyc(4);
        rd(1'b0, gpport_pkg::OFS_SAMPLED, got);
        check(got, 8'hFF);
        wr(1'b0, 5'h12, 8'h04);
        wr(1'b0, 5'h13, 8'h88);
        wait_cyc(4);
        rd(1'b0, gpport_pkg::OFS_SAMPLED, got);
        check(got, 8'hF3);
        check(pad_out, 8'h08);
        check(pad_level, 8'hF3);
        for (int n = 0; n < 8; n++) begin
            wr(1'b0, gpport_pkg::OFS_CONFIG + 5'(n), 8'h00);
        end
    endtask

    // One sense mode on pin 0: a falling then a rising edge, each judged alone.
    task automatic ev_mode(input logic [2:0] m, input logic ef, input logic er);
        ext_en = 8'hFF;
        ext_val = 8'hFF;
        wr(1'b0, gpport_pkg::OFS_CONFIG, {5'h00, m});
        wait_cyc(4);
        wr(1'b0, gpport_pkg::OFS_FLAGS, 8'hFF);
        ext_val = 8'hFE;
        wait_cyc(8);
        rd(1'b0, gpport_pkg::OFS_FLAGS, got);
        check(got, {7'h00, ef});
        check({7'h00, irq}, {7'h00, ef});
        check({7'h00, wake}, {7'h00, m == gpport_pkg::SENSE_LOW});
        ext_val = 8'hFF;
        wait_cyc(8);
        ext_val = 8'hFE;
        wait_cyc(8);
        wr(1'b0, gpport_pkg::OFS_FLAGS, 8'hFF);
        ext_val = 8'hFF;
        wait_cyc(8);
        rd(1'b0, gpport_pkg::OFS_FLAGS, got);
        check(got, {7'h00, er});
        check({7'h00, irq}, {7'h00, er});
        check({7'h00, wake}, 8'h00);
        wr(1'b1, gpport_pkg::ALIAS_FLAGS, 8'hFF);
        wait_cyc(2);
        rd(1'b1, gpport_pkg::ALIAS_FLAGS, got);
        check(got, 8'h00);
        check({7'h00, irq}, 8'h00);
    endtask

    // Toggling polarity on a steady pin raises an any-edge event.
    task automatic t_swap_edge();
        wr(1'b0, gpport_pkg::OFS_CONFIG, 8'h01);
        wait_cyc(4);
        wr(1'b0, gpport_pkg::OFS_FLAGS, 8'hFF);
        wr(1'b0, gpport_pkg::OFS_CONFIG, 8'h81);
        wait_cyc(8);
        rd(1'b0, gpport_pkg::OFS_FLAGS, got);
        check(got, 8'h01);
    endtask

    // Main sequence.
    initial begin
        repeat (10) @(negedge ref_clk);
        nrst = 1'b1;
        t_reset();
        step(gpport_pkg::OFS_ENABLE_SET, 8'h05, 8'h05, 8'h00);
        step(gpport_pkg::OFS_ENABLE_TGL, 8'h03, 8'h06, 8'h00);
        step(gpport_pkg::OFS_ENABLE_CLR, 8'h04, 8'h02, 8'h00);
        step(gpport_pkg::OFS_ENABLE, 8'hA5, 8'hA5, 8'h00);
        step(gpport_pkg::OFS_LEVEL_SET, 8'h0F, 8'hA5, 8'h0F);
        step(gpport_pkg::OFS_LEVEL_CLR, 8'h03, 8'hA5, 8'h0C);
        step(gpport_pkg::OFS_LEVEL_TGL, 8'h11, 8'hA5, 8'h1D);
        step(gpport_pkg::OFS_SAMPLED, 8'h05, 8'hA5, 8'h18);
        step(gpport_pkg::OFS_LEVEL, 8'h3C, 8'hA5, 8'h3C);
        t_alias();
        t_config();
        ev_mode(gpport_pkg::SENSE_INTDIS, 1'b0, 1'b0);
        ev_mode(gpport_pkg::SENSE_ANY, 1'b1, 1'b1);
        ev_mode(gpport_pkg::SENSE_RISE, 1'b0, 1'b1);
        ev_mode(gpport_pkg::SENSE_FALL, 1'b1, 1'b0);
        ev_mode(gpport_pkg::SENSE_LOW, 1'b1, 1'b1);
        t_swap_edge();
        report_and_stop();
    end
endmodule
`default_nettype wire
